// [rtl/cpu_core_consts.vh]
// Constants for the flag, vector and address generation core.
`ifndef CPU_CORE_CONSTS_VH
`define CPU_CORE_CONSTS_VH
// ----------------------------------------
// Reset vectors
// ----------------------------------------
`define VEC_NORM_RESET 16'hFFFE
`define VEC_NORM_CLKMON 16'hFFFC
`define VEC_NORM_WDOG 16'hFFFA
`define VEC_BOOT_RESET 16'hBFFE
`define VEC_BOOT_CLKMON 16'hBFFC
`define VEC_BOOT_WDOG 16'hBFFA
// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define FLG_C 0
`define FLG_V 1
`define FLG_Z 2
`define FLG_N 3
`define FLG_I 4
`define FLG_H 5
`define FLG_X 6
`define FLG_S 7
`define FLAGS_RESET 8'hD0
// ----------------------------------------
// Reset causes, addressing modes, prebytes
// ----------------------------------------
`define CAUSE_PIN 2'h0
`define CAUSE_CLKMON 2'h1
`define CAUSE_WDOG 2'h2
`define AM_INH 3'h0
`define AM_IMM 3'h1
`define AM_DIR 3'h2
`define AM_EXT 3'h3
`define AM_IDX 3'h4
`define AM_REL 3'h5
`define PRE_P1 8'h18
`define PRE_P2 8'h1A
`define PRE_P3 8'hCD
`endif

// [rtl/cpu_flags_vectors_addressing.v]
// CPU core state: program counter, flag register, vectors and addressing.
// Notes on behaviour
// - Sixteen-bit counter holds next fetch address.
// - Normal mode vectors FFFE, FFFC, FFFA by cause.
// - Test or boot vectors BFFE, BFFC, BFFA.
// - Eight-bit flags: C V Z N I H X S.
// - Push, pull, index add, transfers keep flags.
// - Carry from ALU, mul/div error, shifts.
// - Overflow follows arithmetic overflow.
// - Zero on zero result; index step Z only.
// - Negative equals result most significant bit.
// - I mask blocks maskable interrupts; reset sets it.
// - Interrupt sets I after stacking, before vector.
// - Half carry from bit 3 into 4.
// - X masks pin interrupt; acknowledge sets both.
// - X cleared only by transfer or return.
// - Stop acts as no-op while S set.
// - Words big-endian, no alignment imposed.
// - Prebyte redirects opcode page from page 0.
// - Instructions one to five bytes long.
// - Immediate operand follows opcode, width-sized.
// - Direct address high byte forced zero.
// - Extended address from two following bytes.
// - Indexed adds unsigned byte to index.
// - Taken branch adds signed offset to counter.
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_flags_vectors_addressing (
   input wire clk,
   input wire rst,
   input wire boot_mode,
   input wire [1:0] reset_cause,
   input wire vec_hi_valid,
   input wire vec_lo_valid,
   input wire [7:0] vec_byte,
   input wire byte_valid,
   input wire [7:0] fetch_byte,
   input wire [1:0] operand_count,
   input wire [2:0] addr_mode,
   input wire use_second_index,
   input wire [7:0] op_hi,
   input wire [7:0] op_lo,
   input wire [15:0] operand_addr,
   input wire [15:0] first_index_reg,
   input wire [15:0] second_index_reg,
   input wire instr_done,
   input wire branch_taken,
   input wire jump_load,
   input wire keep_flags,
   input wire upd_c,
   input wire upd_v,
   input wire upd_z,
   input wire upd_n,
   input wire upd_h,
   input wire z_only,
   input wire alu_carry,
   input wire alu_overflow,
   input wire alu_half_carry,
   input wire [15:0] alu_result,
   input wire result_wide,
   input wire set_c,
   input wire clr_c,
   input wire set_v,
   input wire clr_v,
   input wire set_i,
   input wire clr_i,
   input wire flags_load,
   input wire flags_from_return,
   input wire [7:0] flags_load_value,
   input wire irq_pending,
   input wire nonmaskable_pin_request,
   input wire regs_stacked,
   input wire stop_instr,
   output reg [15:0] pc,
   output reg [7:0] flag_register,
   output reg [15:0] vector_addr,
   output reg vector_fetch_req,
   output reg irq_accept,
   output reg nmi_accept,
   output reg stop_enter,
   output reg [1:0] page,
   output reg opcode_valid,
   output reg [2:0] instr_len,
   output reg [15:0] ea
);
   // ----------------------------------------
   // Local state
   // ----------------------------------------
   localparam ST_RESET = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_INTR = 3'b100;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [15:0] pc_next;
   reg [7:0] flags_next;
   reg [7:0] vec_hi_reg;
   reg nmi_sel_reg;
   reg [15:0] ea_w;
   reg [15:0] int_vec_base;
   wire [15:0] ea_c;
   wire [1:0] page_c;
   wire opv_c;
   wire [2:0] len_c;
   wire [15:0] pc_seq;
   wire result_zero;
   wire result_msb;
   reg boot_meta_reg;
   reg boot_sync_reg;
   reg nmi_meta_reg;
   reg nmi_sync_reg;
   reg irq_meta_reg;
   reg irq_sync_reg;
   wire nmi_take;
   wire irq_take;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [15:0] reset_vector;
      input boot;
      input [1:0] cause;
      begin
         case (cause)
            `CAUSE_CLKMON: reset_vector = boot ? `VEC_BOOT_CLKMON : `VEC_NORM_CLKMON;
            `CAUSE_WDOG: reset_vector = boot ? `VEC_BOOT_WDOG : `VEC_NORM_WDOG;
            default: reset_vector = boot ? `VEC_BOOT_RESET : `VEC_NORM_RESET;
         endcase
      end
   endfunction

   // Words are big-endian: the first byte fetched is the high half.
   function [15:0] word_of;
      input [7:0] hi_byte;
      input [7:0] lo_byte;
      begin
         word_of = {hi_byte, lo_byte};
      end
   endfunction

   function take_request;
      input request;
      input mask;
      begin
         take_request = request & ~mask;
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers and interrupt gating
   // ----------------------------------------
   // Mode strap and request lines come from outside the clock domain; only stage two is read.
   // The strap stages carry no reset, so the strap has settled before reset is released.
   always @(posedge clk) begin
      boot_meta_reg <= boot_mode;
      boot_sync_reg <= boot_meta_reg;
   end

   // A request is seen two cycles late and must stand until it is accepted.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         nmi_meta_reg <= 1'b0;
         nmi_sync_reg <= 1'b0;
         irq_meta_reg <= 1'b0;
         irq_sync_reg <= 1'b0;
      end else begin
         nmi_meta_reg <= nonmaskable_pin_request;
         nmi_sync_reg <= nmi_meta_reg;
         irq_meta_reg <= irq_pending;
         irq_sync_reg <= irq_meta_reg;
      end
   end

   // The pin request is tested ahead of the maskable one, so it wins a tie.
   assign nmi_take = take_request(nmi_sync_reg, flag_register[`FLG_X]);
   assign irq_take = take_request(irq_sync_reg, flag_register[`FLG_I]);

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   assign pc_seq = pc + {13'h0000, len_c};

   opcode_pager u_pager (
      .clk(clk),
      .rst(rst),
      .byte_valid(byte_valid),
      .fetch_byte(fetch_byte),
      .operand_count(operand_count),
      .page(page_c),
      .opcode_valid(opv_c),
      .instr_len(len_c)
   );

   ea_gen u_ea (
      .mode(addr_mode),
      .pc_next_instr(pc_seq),
      .operand_addr(operand_addr),
      .op_hi(op_hi),
      .op_lo(op_lo),
      .first_index_reg(first_index_reg),
      .second_index_reg(second_index_reg),
      .use_second_index(use_second_index),
      .ea(ea_c)
   );

   // ----------------------------------------
   // Flag computation
   // ----------------------------------------
   assign result_zero = result_wide ? (alu_result == 16'h0000) : (alu_result[7:0] == 8'h00);
   assign result_msb = result_wide ? alu_result[15] : alu_result[7];

   always @* begin
      flags_next = flag_register;
      if (flags_load) begin
         flags_next = flags_load_value;
         // X may fall but never rise by software.
         flags_next[`FLG_X] = flag_register[`FLG_X] & flags_load_value[`FLG_X];
      end else if (!keep_flags) begin
         if (z_only) begin
            flags_next[`FLG_Z] = result_zero;
         end else begin
            if (upd_c) begin
               flags_next[`FLG_C] = alu_carry;
            end
            if (upd_v) begin
               flags_next[`FLG_V] = alu_overflow;
            end
            if (upd_z) begin
               flags_next[`FLG_Z] = result_zero;
            end
            if (upd_n) begin
               flags_next[`FLG_N] = result_msb;
            end
            if (upd_h) begin
               flags_next[`FLG_H] = alu_half_carry;
            end
         end
         if (set_c) begin
            flags_next[`FLG_C] = 1'b1;
         end
         if (clr_c) begin
            flags_next[`FLG_C] = 1'b0;
         end
         if (set_v) begin
            flags_next[`FLG_V] = 1'b1;
         end
         if (clr_v) begin
            flags_next[`FLG_V] = 1'b0;
         end
         if (clr_i) begin
            flags_next[`FLG_I] = 1'b0;
         end
         if (set_i) begin
            flags_next[`FLG_I] = 1'b1;
         end
      end
      // Hardware setting of masks wins over any software write in the same cycle.
      if (state_reg == ST_INTR && regs_stacked) begin
         flags_next[`FLG_I] = 1'b1;
         if (nmi_sel_reg) begin
            flags_next[`FLG_X] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      pc_next = pc;
      irq_accept = 1'b0;
      nmi_accept = 1'b0;
      stop_enter = 1'b0;
      vector_fetch_req = 1'b0;
      int_vec_base = 16'h0000;
      page = page_c;
      opcode_valid = opv_c;
      instr_len = len_c;
      ea = ea_c;
      ea_w = ea_c;
      case (state_reg)
         ST_RESET: begin
            if (vec_lo_valid) begin
               pc_next = word_of(vec_hi_reg, vec_byte);
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (instr_done) begin
               if (stop_instr) begin
                  stop_enter = ~flag_register[`FLG_S];
               end
               if (branch_taken && addr_mode == `AM_REL) begin
                  pc_next = ea_w;
               end else if (jump_load) begin
                  pc_next = ea_w;
               end else begin
                  pc_next = pc_seq;
               end
               if (nmi_take) begin
                  nmi_accept = 1'b1;
                  state_next = ST_INTR;
               end else if (irq_take) begin
                  irq_accept = 1'b1;
                  state_next = ST_INTR;
               end
            end
         end
         ST_INTR: begin
            vector_fetch_req = regs_stacked;
            if (vec_lo_valid) begin
               pc_next = word_of(vec_hi_reg, vec_byte);
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RESET;
      endcase
      vector_addr = (state_reg == ST_RESET) ? reset_vector(boot_sync_reg, reset_cause)
         : int_vec_base;
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_RESET;
         pc <= 16'h0000;
         flag_register <= `FLAGS_RESET;
         vec_hi_reg <= 8'h00;
         nmi_sel_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pc <= pc_next;
         flag_register <= flags_next;
         if (vec_hi_valid) begin
            vec_hi_reg <= vec_byte;
         end
         if (nmi_accept || irq_accept) begin
            nmi_sel_reg <= nmi_accept;
         end
      end
   end
endmodule // cpu_flags_vectors_addressing

// [rtl/ea_gen.v]
// Effective address generator for all addressing modes.
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module ea_gen (
   input wire [2:0] mode,
   input wire [15:0] pc_next_instr,
   input wire [15:0] operand_addr,
   input wire [7:0] op_hi,
   input wire [7:0] op_lo,
   input wire [15:0] first_index_reg,
   input wire [15:0] second_index_reg,
   input wire use_second_index,
   output reg [15:0] ea
);
   reg [15:0] base;
   always @* begin
      base = use_second_index ? second_index_reg : first_index_reg;
      case (mode)
         `AM_IMM: ea = operand_addr;
         `AM_DIR: ea = {8'h00, op_hi};
         `AM_EXT: ea = {op_hi, op_lo};
         `AM_IDX: ea = base + {8'h00, op_hi};
         `AM_REL: ea = pc_next_instr + {{8{op_hi[7]}}, op_hi};
         default: ea = pc_next_instr;
      endcase
   end
endmodule // ea_gen

// [rtl/opcode_pager.v]
// Prebyte tracking and instruction length accounting.
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module opcode_pager (
   input wire clk,
   input wire rst,
   input wire byte_valid,
   input wire [7:0] fetch_byte,
   input wire [1:0] operand_count,
   output reg [1:0] page,
   output wire opcode_valid,
   output reg [2:0] instr_len
);
   reg [1:0] page_reg;
   reg [1:0] page_next;
   reg pre_seen_reg;
   reg is_pre;
   always @* begin
      is_pre = 1'b0;
      page_next = 2'h0;
      if (!pre_seen_reg) begin
         case (fetch_byte)
            `PRE_P1: begin is_pre = 1'b1; page_next = 2'h1; end
            `PRE_P2: begin is_pre = 1'b1; page_next = 2'h2; end
            `PRE_P3: begin is_pre = 1'b1; page_next = 2'h3; end
            default: begin is_pre = 1'b0; page_next = 2'h0; end
         endcase
      end
      page = pre_seen_reg ? page_reg : 2'h0;
      instr_len = {2'h0, pre_seen_reg} + 3'h1 + {1'b0, operand_count};
   end
   assign opcode_valid = byte_valid && !is_pre;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         page_reg <= 2'h0;
         pre_seen_reg <= 1'b0;
      end else if (byte_valid) begin
         page_reg <= page_next;
         pre_seen_reg <= is_pre;
      end
   end
endmodule // opcode_pager

// [tb/cpu_core_sva.sv]
// Assertion checker for the flag, vector and address core.
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_core_sva (
   input wire clk,
   input wire rst,
   input wire [2:0] addr_mode,
   input wire [7:0] op_hi,
   input wire [7:0] op_lo,
   input wire [15:0] first_index_reg,
   input wire use_second_index,
   input wire keep_flags,
   input wire regs_stacked,
   input wire irq_accept,
   input wire stop_enter,
   input wire opcode_valid,
   input wire [1:0] page,
   input wire [1:0] operand_count,
   input wire [2:0] instr_len,
   input wire [7:0] flag_register,
   input wire [15:0] ea
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_dir_high_zero:
      assert property (addr_mode == `AM_DIR |-> ea == {8'h00, op_hi}) else $error("bad direct");
   a_ext_addr_pair:
      assert property (addr_mode == `AM_EXT |-> ea == {op_hi, op_lo}) else $error("bad extended");
   a_idx_sum_wraps:
      assert property (addr_mode == `AM_IDX && !use_second_index
         |-> ea == first_index_reg + {8'h00, op_hi}) else $error("bad indexed");
   a_keep_flags_hold:
      assert property (keep_flags && !regs_stacked |=> $stable(flag_register))
         else $error("flags moved");
   a_x_hw_only:
      assert property ($rose(flag_register[6]) |-> $past(regs_stacked)) else $error("x set");
   a_i_blocks_irq:
      assert property (flag_register[4] |-> !irq_accept) else $error("irq while masked");
   a_stop_as_nop:
      assert property (flag_register[7] |-> !stop_enter) else $error("stop while disabled");
   a_len_page_zero:
      assert property (opcode_valid && page == 2'h0
         |-> instr_len == {1'b0, operand_count} + 3'h1) else $error("bad length");
   a_len_paged:
      assert property (opcode_valid && page != 2'h0
         |-> instr_len == {1'b0, operand_count} + 3'h2) else $error("bad paged length");
   cover property (opcode_valid && page == 2'h3);
   cover property (regs_stacked);
   cover property (addr_mode == `AM_IDX && ea < first_index_reg);
endmodule // cpu_core_sva
bind cpu_flags_vectors_addressing cpu_core_sva chk (.*);

// [tb/cpu_flags_vectors_addressing_tb.sv]
// Self-checking bench for the flag, vector and address core.
`timescale 1ns/1ps
module cpu_flags_vectors_addressing_tb;
reg clk = 0, rst = 1, boot_mode = 0, vec_hi_valid = 0, vec_lo_valid = 0, byte_valid = 0;
reg use_second_index = 0, instr_done = 0, branch_taken = 0, jump_load = 0, keep_flags = 0;
reg upd_c = 0, upd_v = 0, upd_z = 0, upd_n = 0, upd_h = 0, z_only = 0, alu_carry = 0;
reg alu_overflow = 0, alu_half_carry = 0, result_wide = 0, flags_load = 0;
reg flags_from_return = 0, irq_pending = 0, nonmaskable_pin_request = 0, regs_stacked = 0;
reg stop_instr = 0;
reg [5:0] sc = 0;
reg [1:0] reset_cause = 0, operand_count = 0;
reg [2:0] addr_mode = 0;
reg [7:0] fetch_byte = 0, op_hi = 0, op_lo = 0, flags_load_value = 0, fx;
reg [15:0] operand_addr = 0, first_index_reg = 0, second_index_reg = 0, alu_result = 0, x;
reg [31:0] r;
reg [19:0] q[$];
reg [19:0] n;
integer seed = 27, errors = 0, checks_done = 0, i, b;
wire set_c = sc[0], clr_c = sc[1], set_v = sc[2], clr_v = sc[3], set_i = sc[4], clr_i = sc[5];
wire [7:0] vec_byte, flag_register;
wire [15:0] pc, vector_addr, ea;
wire [1:0] page;
wire [2:0] instr_len;
wire vector_fetch_req, irq_accept, nmi_accept, stop_enter, opcode_valid;
cpu_flags_vectors_addressing uut (.*);
sys_memory mem (.addr(vector_addr + {15'h0, vec_lo_valid}), .rd_data(vec_byte));
always #5 clk = ~clk;
// ----------------------------------------
// Checking
// ----------------------------------------
function [15:0] obs(input [3:0] s);
   case (s)
      0: obs = pc;
      1: obs = {8'h00, flag_register};
      2: obs = ea;
      3: obs = {13'h0, instr_len};
      4: obs = {14'h0, page};
      5: obs = vector_addr;
      6: obs = {15'h0, irq_accept};
      7: obs = {15'h0, nmi_accept};
      8: obs = {15'h0, stop_enter};
      default: obs = {15'h0, vector_fetch_req};
   endcase
endfunction
function [7:0] mb(input [15:0] a);
   mb = a[15:8] ^ a[7:0] ^ 8'h5A;
endfunction
task chk(input [15:0] seen, input [15:0] exp);
   checks_done = checks_done + 1;
   if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
   end
endtask
task note(input [3:0] s, input [15:0] e);
   q.push_back({s, e});
endtask
always @(negedge clk) while (q.size() > 0) begin
   n = q.pop_front();
   chk(obs(n[19:16]), n[15:0]);
end
task stop_test;
   $display("checks %0d errors %0d", checks_done, errors);
   if (errors == 0 && checks_done > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
initial begin
   repeat (5000) @(posedge clk);
   errors = errors + 1;
   stop_test;
end
// ----------------------------------------
// Stimulus
// ----------------------------------------
task tick;
   @(posedge clk);
   #1;
endtask
task vec(input [15:0] v);
   note(5, v);
   vec_hi_valid = 1;
   tick;
   vec_hi_valid = 0;
   vec_lo_valid = 1;
   tick;
   vec_lo_valid = 0;
   note(0, {mb(v), mb(v + 16'h1)});
endtask
task ld(input [7:0] v);
   tick;
   flags_load = 1;
   flags_load_value = v;
   tick;
   flags_load = 0;
   fx = (v & 8'hBF) | (v & fx & 8'h40);
   note(1, fx);
endtask
task intr(input nmi);
   irq_pending = !nmi;
   nonmaskable_pin_request = nmi;
   tick;
   tick;
   instr_done = 1;
   stop_instr = 1;
   note(nmi ? 4'h7 : 4'h6, 16'h1);
   note(8, {15'h0, !fx[7]});
   tick;
   {instr_done, stop_instr, irq_pending, nonmaskable_pin_request, regs_stacked} = 5'h01;
   note(9, 16'h1);
   tick;
   regs_stacked = 0;
   fx = fx | (nmi ? 8'h50 : 8'h10);
   note(1, fx);
   vec(16'h0000);
endtask
initial begin
   for (b = 0; b < 6; b = b + 1) begin
      tick;
      rst = 1;
      boot_mode = b > 2;
      reset_cause = b % 3;
      repeat (b == 0 ? 12 : 2) tick;
      rst = 0;
      vec({boot_mode ? 8'hBF : 8'hFF, 8'hFE - {5'h0, reset_cause, 1'b0}});
      note(1, 16'hD0);
   end
   $display("end vectors");
   fx = 8'hD0;
   irq_pending = 1;
   tick;
   tick;
   {irq_pending, instr_done, stop_instr} = 3'h7;
   note(6, 0);
   note(8, 0);
   tick;
   {irq_pending, instr_done, stop_instr} = 3'h0;
   ld(8'h00);
   {upd_c, upd_v, upd_z, upd_n, upd_h} = 5'h1F;
   for (i = 0; i < 18; i = i + 1) begin
      r = $random(seed);
      if (i == 4) r[7:0] = 8'h00;
      {alu_carry, alu_overflow, alu_half_carry} = r[18:16];
      alu_result = r[15:0];
      keep_flags = i % 3 == 2;
      z_only = i > 15;
      result_wide = z_only;
      if (z_only) alu_result = {i[0], 15'h0};
      tick;
      if (z_only && !keep_flags) fx[2] = alu_result == 0;
      else if (!keep_flags) fx = {fx[7:6], r[16], fx[4], r[7], r[7:0] == 0, r[17], r[18]};
      note(1, fx);
   end
   {upd_c, upd_v, upd_z, upd_n, upd_h, keep_flags, z_only} = 7'h0;
   for (i = 0; i < 6; i = i + 1) begin
      sc = 6'h01 << i;
      tick;
      sc = 0;
      fx[i < 4 ? i / 2 : 4] = !i[0];
      note(1, fx);
   end
   intr(0);
   ld(8'h00);
   intr(1);
   ld(8'h00);
   ld(8'h40);
   $display("end flags");
   for (i = 0; i < 16; i = i + 1) begin
      tick;
      r = $random(seed);
      addr_mode = 1 + i % 4;
      {op_hi, op_lo, use_second_index} = r[16:0];
      first_index_reg = {8'hFF, r[31:24]};
      second_index_reg = r[31:16];
      operand_addr = r[27:12];
      x = use_second_index ? second_index_reg : first_index_reg;
      case (addr_mode)
         1: note(2, operand_addr);
         2: note(2, {8'h00, op_hi});
         3: note(2, {op_hi, op_lo});
         default: note(2, x + {8'h00, op_hi});
      endcase
   end
   $display("end addressing");
   x = {mb(16'h0000), mb(16'h0001)};
   for (i = 0; i < 3; i = i + 1) begin
      tick;
      r = $random(seed);
      {op_hi, op_lo} = r[15:0];
      addr_mode = i == 2 ? 3'h3 : 3'h5;
      operand_count = 2'h1;
      {instr_done, branch_taken, jump_load} = {1'b1, i == 0, i == 2};
      tick;
      instr_done = 0;
      if (i == 2) x = {op_hi, op_lo};
      else x = x + 16'h0002 + (i == 0 ? {{8{op_hi[7]}}, op_hi} : 16'h0000);
      note(0, x);
   end
   {branch_taken, jump_load} = 2'h0;
   $display("end branching");
   for (i = 0; i < 4; i = i + 1) begin
      tick;
      operand_count = $random(seed);
      if (i > 0) begin
         byte_valid = 1;
         fetch_byte = i == 1 ? 8'h18 : i == 2 ? 8'h1A : 8'hCD;
         tick;
      end
      byte_valid = 1;
      fetch_byte = 8'h86;
      note(4, i);
      note(3, (i > 0) + 1 + operand_count);
      tick;
      byte_valid = 0;
   end
   $display("end paging");
   tick;
   tick;
   stop_test;
end
endmodule // cpu_flags_vectors_addressing_tb

// [tb/sys_memory.sv]
// Memory map model that serves the vector bytes.
`timescale 1ns/1ps
module sys_memory (
   input wire [15:0] addr,
   output wire [7:0] rd_data
);
   // Each byte mixes its own address, so every word read is predictable.
   assign rd_data = addr[15:8] ^ addr[7:0] ^ 8'h5A;
endmodule // sys_memory
